// file: logic/tecs_pkg.sv
// constants and types shared by the timer event capture and square-wave block
package tecs_pkg;

  // register port widths
  localparam int unsigned TECS_ADDR_W = 4;
  localparam int unsigned TECS_DATA_W = 16;

  // register offsets, one word each
  localparam logic [3:0] OFS_PRESC = 4'h0;
  localparam logic [3:0] OFS_CCCTRL = 4'h1;
  localparam logic [3:0] OFS_MODE = 4'h2;
  localparam logic [3:0] OFS_OUTCTRL = 4'h3;
  localparam logic [3:0] OFS_CCA = 4'h4;
  localparam logic [3:0] OFS_CCB = 4'h5;
  localparam logic [3:0] OFS_COUNT = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;
  localparam logic [3:0] OFS_MASK = 4'h8;

  // field positions
  localparam int unsigned PRM_CKS_LSB = 0;
  localparam int unsigned PRM_ESA_LSB = 4;
  localparam int unsigned PRM_ESB_LSB = 6;
  localparam int unsigned CCC_CAPA_BIT = 0;
  localparam int unsigned CCC_CAPB_BIT = 2;
  localparam int unsigned MODE_RUN_LSB = 2;
  localparam int unsigned OUT_OE_BIT = 0;
  localparam int unsigned OUT_TOG_BIT = 1;
  localparam int unsigned STS_A_BIT = 0;
  localparam int unsigned STS_B_BIT = 1;
  localparam int unsigned STS_OVF_BIT = 2;

  // reset values and the counter's top value
  localparam logic [7:0] RST_PRESC = 8'h00;
  localparam logic [7:0] RST_CCCTRL = 8'h00;
  localparam logic [15:0] RST_CC = 16'h0000;
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // last prescaler count of each division ratio
  localparam logic [7:0] DIV1_LAST = 8'h00;
  localparam logic [7:0] DIV4_LAST = 8'h03;
  localparam logic [7:0] DIV256_LAST = 8'hff;

  typedef enum logic [1:0] {
    TECS_RUN_STOP = 2'b00,
    TECS_RUN_FREE = 2'b01,
    TECS_RUN_RESTART = 2'b10,
    TECS_RUN_MATCHCLR = 2'b11
  } tecs_run_t;

  typedef enum logic [1:0] {
    TECS_ES_FALL = 2'b00,
    TECS_ES_RISE = 2'b01,
    TECS_ES_NONE = 2'b10,
    TECS_ES_BOTH = 2'b11
  } tecs_esel_t;

  typedef enum logic [1:0] {
    TECS_CK_DIV1 = 2'b00,
    TECS_CK_DIV4 = 2'b01,
    TECS_CK_DIV256 = 2'b10,
    TECS_CK_EXT = 2'b11
  } tecs_cks_t;

endpackage : tecs_pkg

// file: logic/tecs_edge_if.sv
// interface between the timer core and one input edge filter
`timescale 1ns/100ps
`default_nettype none
interface tecs_edge_if;
  logic sample;
  logic din;
  logic [1:0] esel;
  logic edge_p;
  modport filt (input sample, input din, input esel, output edge_p);
  modport user (output sample, output din, output esel, input edge_p);
endinterface : tecs_edge_if
`default_nettype wire

// file: logic/tecs_presc.sv
// prescaler producing the count-clock tick
`timescale 1ns/100ps
`default_nettype none
module tecs_presc
  import tecs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [1:0] cks_i,
  output logic tick_o
);

  typedef struct packed {
    logic [7:0] cnt;
  } tecs_presc_st_t;

  tecs_presc_st_t q, d;

  // last count for the selected ratio; external mode samples every clock
  function automatic logic [7:0] div_last(input logic [1:0] cks);
    unique case (cks)
      TECS_CK_DIV4: div_last = DIV4_LAST;
      TECS_CK_DIV256: div_last = DIV256_LAST;
      default: div_last = DIV1_LAST;
    endcase
  endfunction : div_last

  // free-running divider, wraps at the selected ratio
  always_comb begin
    d = q;
    if (q.cnt >= div_last(cks_i)) begin
      d.cnt = 8'h00;
    end else begin
      d.cnt = 8'(q.cnt + 8'h01);
    end
  end

  assign tick_o = (q.cnt >= div_last(cks_i));

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : tecs_presc
`default_nettype wire

// file: logic/tecs_edge_filt.sv
// two-sample noise filter and valid-edge detector for one input pin
`timescale 1ns/100ps
`default_nettype none
module tecs_edge_filt
  import tecs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  tecs_edge_if.filt eif
);

  typedef struct packed {
    logic smp;
    logic lvl;
    logic ev;
  } tecs_filt_st_t;

  tecs_filt_st_t q, d;

  // accepted level starts low, so a high pin after reset yields a rising edge
  always_comb begin
    d = q;
    d.ev = 1'b0;
    if (eif.sample) begin
      d.smp = eif.din;
      if ((eif.din == q.smp) && (q.smp != q.lvl)) begin
        d.lvl = q.smp;
        unique case (tecs_esel_t'(eif.esel))
          TECS_ES_RISE: d.ev = q.smp;
          TECS_ES_FALL: d.ev = ~q.smp;
          TECS_ES_BOTH: d.ev = 1'b1;
          TECS_ES_NONE: d.ev = 1'b0;
        endcase
      end
    end
  end

  assign eif.edge_p = q.ev;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : tecs_edge_filt
`default_nettype wire

// file: logic/tecs_top.sv
// 16-bit timer core: event counting, pulse-width capture, square-wave output
//
// Overview of operation
// [R01] event counting waits for twice-confirmed edge
// [R02] free-run capture or restart-on-edge measurement
// [R03] inputs sampled by count clock, two samples
// [R04] edge on input A captures into B
// [R05] two-width mode: input A edge sets B
// [R06] input B edge captures into A
// [R07] software trusts widths within one counter cycle
// [R08] software reads capture, checks, clears overflow
// [R09] restart mode captures then clears counter
// [R10] restart with both edges blocks capture A
// [R11] enable and toggle bits invert output on match
// [R12] software loads nonzero compare A first
// [R13] square-wave setup order ends with mode
// [R14] software avoids changing compare A running
// [R15] measurement setup order ends with mode
// [R16] software sets both capture pins as inputs
// [R17] nonzero run bits count, zero stops
// [R18] square period is twice (compare plus one)
`timescale 1ns/100ps
`default_nettype none
module tecs_top
  import tecs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [TECS_ADDR_W-1:0] addr_i,
  input wire logic [TECS_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [TECS_DATA_W-1:0] rdata_o,
  input wire logic capture_input_a_i,
  input wire logic capture_input_b_i,
  output logic timer_output_pin_o,
  output logic timer_output_oe_o,
  output logic irq_o
);

  typedef struct packed {
    logic [7:0] presc;
    logic [7:0] ccc;
    logic [1:0] run;
    logic [1:0] outc;
    logic [15:0] cca;
    logic [15:0] ccb;
    logic [15:0] cnt;
    logic [2:0] sts;
    logic [2:0] msk;
    logic out;
    logic [15:0] rdata;
  } tecs_regs_t;

  tecs_regs_t q, d;

  tecs_run_t run_e;
  tecs_cks_t cks_e;
  logic running;
  logic presc_tick;
  logic edge_a;
  logic edge_b;
  logic tick;
  logic cap_a_mode;
  logic cap_b_mode;
  logic cap_a_ev;
  logic cap_b_ev;
  logic match_a;
  logic match_b;
  logic ovf_ev;
  logic [15:0] cnt_inc;

  tecs_edge_if eif_a ();
  tecs_edge_if eif_b ();

  // decoded control fields
  assign run_e = tecs_run_t'(q.run);
  assign cks_e = tecs_cks_t'(q.presc[PRM_CKS_LSB +: 2]);
  // [R17] run bits gate counting
  assign running = (run_e != TECS_RUN_STOP);

  tecs_presc u_presc (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .cks_i(q.presc[PRM_CKS_LSB +: 2]),
    .tick_o(presc_tick)
  );

  // [R03] both pins sampled at the count-clock rate
  assign eif_a.sample = presc_tick;
  assign eif_a.din = capture_input_a_i;
  assign eif_a.esel = q.presc[PRM_ESA_LSB +: 2];
  assign eif_b.sample = presc_tick;
  assign eif_b.din = capture_input_b_i;
  assign eif_b.esel = q.presc[PRM_ESB_LSB +: 2];

  tecs_edge_filt u_filt_a (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .eif(eif_a)
  );

  tecs_edge_filt u_filt_b (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .eif(eif_b)
  );

  // a stopped timer ignores pin activity entirely
  assign edge_a = running & eif_a.edge_p;
  assign edge_b = running & eif_b.edge_p;

  // [R01] external mode counts only filtered input A edges
  assign tick = running & ((cks_e == TECS_CK_EXT) ? eif_a.edge_p : presc_tick);
  assign cnt_inc = 16'(q.cnt + 16'h0001);

  // [R02] register roles follow control bits and run mode
  assign cap_a_mode = q.ccc[CCC_CAPA_BIT];
  assign cap_b_mode = q.ccc[CCC_CAPB_BIT] | (run_e == TECS_RUN_RESTART);

  // [R04] [R05] [R09] input A edge loads register B
  assign cap_b_ev = edge_a & cap_b_mode;
  // [R06] [R10] input B edge loads register A, blocked in restart with both edges
  assign cap_a_ev = edge_b & cap_a_mode &
    ~((run_e == TECS_RUN_RESTART) && (q.presc[PRM_ESA_LSB +: 2] == TECS_ES_BOTH));

  // compare matches on a count-clock tick
  assign match_a = tick & ~cap_a_mode & (q.cnt == q.cca);
  assign match_b = tick & ~cap_b_mode & (q.cnt == q.ccb);

  // wrap past all ones, not counting a clear that happens instead
  assign ovf_ev = tick & (q.cnt == CNT_MAX) &
    ~((run_e == TECS_RUN_MATCHCLR) && match_a) &
    ~((run_e == TECS_RUN_RESTART) && edge_a);

  // next-state of all registers
  always_comb begin
    d = q;
    d.rdata = 16'h0000;
    // software writes; capture registers are read-only while capturing
    if (wr_i) begin
      case (addr_i)
        OFS_PRESC: d.presc = wdata_i[7:0];
        OFS_CCCTRL: d.ccc = wdata_i[7:0];
        OFS_MODE: d.run = wdata_i[MODE_RUN_LSB +: 2];
        OFS_OUTCTRL: d.outc = wdata_i[1:0];
        OFS_CCA: begin
          if (!cap_a_mode) begin
            d.cca = wdata_i;
          end
        end
        OFS_CCB: begin
          if (!cap_b_mode) begin
            d.ccb = wdata_i;
          end
        end
        OFS_STATUS: d.sts = q.sts & ~wdata_i[2:0];
        OFS_MASK: d.msk = wdata_i[2:0];
        default: ;
      endcase
    end
    // counter per run mode
    unique case (run_e)
      TECS_RUN_STOP: d.cnt = 16'h0000;
      TECS_RUN_FREE: begin
        if (tick) begin
          d.cnt = cnt_inc;
        end
      end
      TECS_RUN_RESTART: begin
        // [R09] capture uses the old count, then count from zero
        if (edge_a) begin
          d.cnt = 16'h0000;
        end else if (tick) begin
          d.cnt = cnt_inc;
        end
      end
      TECS_RUN_MATCHCLR: begin
        // [R18] clear after compare A gives N+1 ticks per half period
        if (tick) begin
          d.cnt = match_a ? 16'h0000 : cnt_inc;
        end
      end
    endcase
    // captures take the count before this cycle's update
    if (cap_b_ev) begin
      d.ccb = q.cnt;
    end
    if (cap_a_ev) begin
      d.cca = q.cnt;
    end
    // [R11] output inverts on compare A match when enabled
    if (!q.outc[OUT_OE_BIT]) begin
      d.out = 1'b0;
    end else if (q.outc[OUT_TOG_BIT] && match_a) begin
      d.out = ~q.out;
    end
    // sticky events are applied after the clear, so a set wins
    d.sts[STS_A_BIT] = d.sts[STS_A_BIT] | cap_a_ev | match_a;
    d.sts[STS_B_BIT] = d.sts[STS_B_BIT] | cap_b_ev | match_b;
    d.sts[STS_OVF_BIT] = d.sts[STS_OVF_BIT] | ovf_ev;
    // read data held for exactly the cycle after the strobe
    if (rd_i) begin
      case (addr_i)
        OFS_PRESC: d.rdata = {8'h00, q.presc};
        OFS_CCCTRL: d.rdata = {8'h00, q.ccc};
        OFS_MODE: d.rdata = {12'h000, q.run, 2'b00};
        OFS_OUTCTRL: d.rdata = {14'h0, q.outc};
        OFS_CCA: d.rdata = q.cca;
        OFS_CCB: d.rdata = q.ccb;
        OFS_COUNT: d.rdata = q.cnt;
        OFS_STATUS: d.rdata = {13'h0, q.sts};
        OFS_MASK: d.rdata = {13'h0, q.msk};
        default: d.rdata = 16'h0000;
      endcase
    end
  end

  // single register bank for this module; prescaler and edge filters keep their own
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q.presc <= RST_PRESC;
      q.ccc <= RST_CCCTRL;
      q.run <= TECS_RUN_STOP;
      q.outc <= 2'b00;
      q.cca <= RST_CC;
      q.ccb <= RST_CC;
      q.cnt <= RST_CC;
      q.sts <= 3'h0;
      q.msk <= RST_MASK;
      q.out <= 1'b0;
      q.rdata <= 16'h0000;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops except the mask combine
  assign rdata_o = q.rdata;
  assign timer_output_pin_o = q.out;
  assign timer_output_oe_o = q.outc[OUT_OE_BIT];
  assign irq_o = |(q.sts & q.msk);

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // [R01] no input A edge, no count in external mode
  ext_count_hold_a: assert property ( // [R01]
    (running && cks_e == TECS_CK_EXT && !eif_a.edge_p && !wr_i) |=> $stable(q.cnt)
  ) else $error("external count moved without a filtered edge");

  // [R03] an edge needs the same level on the two samples before it
  glitch_reject_a: assert property ( // [R03]
    (eif_a.edge_p && $past(presc_tick, 2)) |->
    ($past(eif_a.din) == $past(eif_a.din, 2))
  ) else $error("input A edge accepted on a single sample");

  // [R17] a stopped counter reads zero one cycle later
  stop_clears_a: assert property ( // [R17]
    (run_e == TECS_RUN_STOP && !wr_i) |=> (q.cnt == 16'h0000)
  ) else $error("stopped counter not held at zero");

  // [R04] [R05] [R09] capture B takes the prior count and raises status B
  cap_b_load_a: assert property ( // [R04] [R05] [R09]
    cap_b_ev |=> (q.ccb == $past(q.cnt)) && q.sts[STS_B_BIT]
  ) else $error("capture B did not load count or flag");

  // [R06] capture A takes the prior count and raises status A
  cap_a_load_a: assert property ( // [R06]
    cap_a_ev |=> (q.cca == $past(q.cnt)) && q.sts[STS_A_BIT]
  ) else $error("capture A did not load count or flag");

  // [R09] restart clears the counter on the edge
  restart_clear_a: assert property ( // [R09]
    (run_e == TECS_RUN_RESTART && edge_a && !wr_i) |=> (q.cnt == 16'h0000)
  ) else $error("restart edge did not clear the counter");

  // [R10] restart with both edges leaves register A untouched
  no_cap_a_a: assert property ( // [R10]
    (run_e == TECS_RUN_RESTART && cap_a_mode && edge_b &&
     q.presc[PRM_ESA_LSB +: 2] == TECS_ES_BOTH) |=> $stable(q.cca)
  ) else $error("register A captured in restart with both edges");

  // [R11] enabled toggle inverts the pin on match
  toggle_match_a: assert property ( // [R11]
    (match_a && q.outc == 2'b11 && !wr_i) |=> (timer_output_pin_o != $past(q.out))
  ) else $error("output did not invert on compare match");

  // [R18] a compare A match in match-clear mode brings the count back to zero one cycle later
  sq_restart_a: assert property ( // [R18]
    (run_e == TECS_RUN_MATCHCLR && match_a && !wr_i) |=> (q.cnt == 16'h0000)
  ) else $error("match did not restart count from zero");

  // set wins over a same-cycle write-one clear
  set_wins_a: assert property (
    (cap_b_ev && wr_i && addr_i == OFS_STATUS && wdata_i[STS_B_BIT]) |=> q.sts[STS_B_BIT]
  ) else $error("status B lost to a simultaneous clear");

  // count register reads back one cycle after the strobe
  read_count_a: assert property (
    (rd_i && addr_i == OFS_COUNT) |=> (rdata_o == $past(q.cnt))
  ) else $error("count readback mismatch");

  // level interrupt follows masked status
  irq_level_a: assert property (
    (q.sts[STS_OVF_BIT] && q.msk[STS_OVF_BIT]) |-> irq_o
  ) else $error("unmasked overflow not on interrupt");

  // read data stands one cycle only, then returns to zero
  rdata_idle_a: assert property (
    !rd_i |=> (rdata_o == 16'h0000)
  ) else $error("read data left standing without a strobe");

  // [R11] output held low while its enable is off
  out_off_a: assert property ( // [R11]
    !q.outc[OUT_OE_BIT] |=> !timer_output_pin_o
  ) else $error("output pin high with enable off");

  // [R11] a compare A match raises status A
  match_flag_a: assert property ( // [R11]
    match_a |=> q.sts[STS_A_BIT]
  ) else $error("compare match did not raise status A");

  // [R17] free run adds exactly one per count-clock tick
  free_count_a: assert property ( // [R17]
    (run_e == TECS_RUN_FREE && tick && !wr_i) |=> (q.cnt == 16'($past(q.cnt) + 16'h0001))
  ) else $error("free-running counter skipped or stalled");

  // [R17] a stopped timer raises no capture, match or overflow
  stop_quiet_a: assert property ( // [R17]
    (run_e == TECS_RUN_STOP) |-> !(cap_a_ev || cap_b_ev || match_a || match_b || ovf_ev)
  ) else $error("event raised while stopped");

  // [R02] a free-running wrap sets the overflow flag for software
  ovf_set_a: assert property ( // [R02]
    (run_e == TECS_RUN_FREE && tick && q.cnt == CNT_MAX) |=> q.sts[STS_OVF_BIT]
  ) else $error("counter wrap did not set overflow");

  // [R03] an accepted edge is one pulse; the next needs fresh samples
  edge_single_a: assert property ( // [R03]
    eif_a.edge_p |=> !eif_a.edge_p
  ) else $error("input A edge pulse longer than one cycle");

endmodule : tecs_top
`default_nettype wire

// file: sim/tecs_pin_model.sv
// partner model: pulse sources on both capture pins and a load on the timer output
`timescale 1ns/100ps
`default_nettype none
module tecs_pin_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic tout_i,
  input wire logic toe_i,
  output logic pin_a_o,
  output logic pin_b_o,
  output logic [15:0] half_o,
  output logic [15:0] toggles_o
);
  logic prev_q;
  logic [15:0] run_q;

  // both pins driven
  // pins are always driven by this model, never left floating
  initial begin
    pin_a_o = 1'b0;
    pin_b_o = 1'b0;
  end

  // widths within one cycle
  // high pulse of width cycles; callers keep widths far below a counter wrap
  task automatic pulse(input bit sel, input int unsigned width);
    @(posedge clk_sys_i);
    if (sel) pin_b_o <= 1'b1;
    else pin_a_o <= 1'b1;
    repeat (width) @(posedge clk_sys_i);
    if (sel) pin_b_o <= 1'b0;
    else pin_a_o <= 1'b0;
  endtask : pulse

  // load side: length of the last output half period and number of inversions
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
      run_q <= 16'h0001;
      half_o <= 16'h0000;
      toggles_o <= 16'h0000;
    end else begin
      prev_q <= tout_i;
      if (toe_i && (tout_i !== prev_q)) begin
        half_o <= run_q;
        run_q <= 16'h0001;
        toggles_o <= toggles_o + 16'h0001;
      end else begin
        run_q <= run_q + 16'h0001;
      end
    end
  end
endmodule : tecs_pin_model
`default_nettype wire

// file: sim/tb_top.sv
// self-checking testbench for the timer capture and square-wave block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import tecs_pkg::*;
;
  logic clk_sys, rst, wr, rd, pin_a, pin_b, tout, toe, irq;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, v, c1, c2, half, toggles;
  int fail_count;
  int checked;

  tecs_top i_dut (.clk_sys_i(clk_sys), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .capture_input_a_i(pin_a),
    .capture_input_b_i(pin_b), .timer_output_pin_o(tout), .timer_output_oe_o(toe),
    .irq_o(irq));

  tecs_pin_model i_src (.clk_sys_i(clk_sys), .rst_i(rst), .tout_i(tout), .toe_i(toe),
    .pin_a_o(pin_a), .pin_b_o(pin_b), .half_o(half), .toggles_o(toggles));

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // one-cycle write strobe; a gap cycle follows so wr is never set twice at one edge
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // watchdog: 80,000 cycles, most of the run spent waiting for one counter wrap
  initial begin
    repeat (80000) @(posedge clk_sys);
    fail_count++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    fail_count = 0;
    checked = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    // reset state, unmapped index ignored on write and read as zero
    wr_reg(4'h9, 16'hffff);
    for (int i = 0; i < 10; i++) begin
      rd_reg(i[3:0], v);
      chk16(v, 16'h0000);
    end
    chk1(toe, 1'b0);
    chk1(irq, 1'b0);
    // free run counts one per tick, stop clears
    wr_reg(OFS_MODE, 16'h0004);
    rd_reg(OFS_COUNT, c1);
    rd_reg(OFS_COUNT, c2);
    chk16(c2 - c1, 16'h0002);
    wr_reg(OFS_MODE, 16'h0000);
    rd_reg(OFS_COUNT, v);
    chk16(v, 16'h0000);
    // divide-by-four count clock: two ticks in any eight cycles
    wr_reg(OFS_PRESC, 16'h0001);
    wr_reg(OFS_MODE, 16'h0004);
    rd_reg(OFS_COUNT, c1);
    repeat (6) @(posedge clk_sys);
    rd_reg(OFS_COUNT, c2);
    chk16(c2 - c1, 16'h0002);
    wr_reg(OFS_MODE, 16'h0000);
    wr_reg(OFS_CCCTRL, 16'h0005);
    wr_reg(OFS_PRESC, 16'h00f0);
    wr_reg(OFS_MASK, 16'h0003);
    wr_reg(OFS_MODE, 16'h0004);
    // width on input A measured as difference of two captures into B
    fork
      i_src.pulse(1'b0, 40);
    join_none
    repeat (12) @(posedge clk_sys);
    rd_reg(OFS_CCB, c1);
    rd_reg(OFS_STATUS, v);
    chk16(v & 16'h0002, 16'h0002);
    chk1(irq, 1'b1);
    wr_reg(OFS_MASK, 16'h0000);
    repeat (2) @(posedge clk_sys);
    chk1(irq, 1'b0);
    wr_reg(OFS_MASK, 16'h0003);
    wr_reg(OFS_STATUS, 16'h0007);
    repeat (2) @(posedge clk_sys);
    chk1(irq, 1'b0);
    repeat (50) @(posedge clk_sys);
    rd_reg(OFS_CCB, c2);
    chk16(c2 - c1, 16'h0028);
    // a one-sample glitch on B must not capture
    i_src.pulse(1'b1, 1);
    repeat (10) @(posedge clk_sys);
    rd_reg(OFS_STATUS, v);
    chk16(v & 16'h0001, 16'h0000);
    fork
      i_src.pulse(1'b1, 30);
    join_none
    repeat (12) @(posedge clk_sys);
    rd_reg(OFS_CCA, c1);
    rd_reg(OFS_STATUS, v);
    chk16(v & 16'h0001, 16'h0001);
    repeat (40) @(posedge clk_sys);
    rd_reg(OFS_CCA, c2);
    chk16(c2 - c1, 16'h001e);
    // restart mode: the counter restarts on each A edge
    wr_reg(OFS_MODE, 16'h0000);
    wr_reg(OFS_MODE, 16'h0008);
    i_src.pulse(1'b0, 50);
    repeat (20) @(posedge clk_sys);
    rd_reg(OFS_CCB, v);
    // cleared on the opening edge, so fifty cycles read back as 49
    chk16(v, 16'h0031);
    rd_reg(OFS_CCA, c1);
    i_src.pulse(1'b1, 20);
    repeat (20) @(posedge clk_sys);
    rd_reg(OFS_CCA, c2);
    chk16(c2, c1);
    // external events: three rising edges on A give a count of three
    wr_reg(OFS_MODE, 16'h0000);
    wr_reg(OFS_PRESC, 16'h0013);
    wr_reg(OFS_MODE, 16'h0004);
    for (int i = 0; i < 3; i++) begin
      i_src.pulse(1'b0, 4);
      repeat (4) @(posedge clk_sys);
    end
    rd_reg(OFS_COUNT, v);
    chk16(v, 16'h0003);
    // capture B and a write-one clear of status B meet in one cycle
    fork
      i_src.pulse(1'b0, 4);
    join_none
    repeat (2) @(posedge clk_sys);
    wr_reg(OFS_STATUS, 16'h0002);
    rd_reg(OFS_STATUS, v);
    chk16(v & 16'h0002, 16'h0002);
    wr_reg(OFS_MODE, 16'h0000);
    wr_reg(OFS_PRESC, 16'h0000);
    wr_reg(OFS_CCCTRL, 16'h0000);
    wr_reg(OFS_OUTCTRL, 16'h0003);
    wr_reg(OFS_CCA, 16'h0004);
    wr_reg(OFS_MODE, 16'h000c);
    repeat (40) @(posedge clk_sys);
    c1 = toggles;
    chk1(toe, 1'b1);
    chk16(half, 16'h0005);
    repeat (100) @(posedge clk_sys);
    chk16(toggles - c1, 16'h0014);
    // let the counter wrap once, read capture, check and clear overflow
    wr_reg(OFS_MODE, 16'h0000);
    wr_reg(OFS_STATUS, 16'h0007);
    wr_reg(OFS_MASK, 16'h0004);
    wr_reg(OFS_MODE, 16'h0004);
    repeat (65540) @(posedge clk_sys);
    rd_reg(OFS_CCB, c1);
    rd_reg(OFS_STATUS, v);
    chk16(v & 16'h0004, 16'h0004);
    chk1(irq, 1'b1);
    wr_reg(OFS_STATUS, 16'h0004);
    rd_reg(OFS_STATUS, v);
    chk16(v & 16'h0004, 16'h0000);
    chk1(irq, 1'b0);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
